// ### design/cca_pkg.sv
// ==========================================================================
// shared constants for the counter array module mode control
// ==========================================================================
package cca_pkg;
  // ==========================================================================
  // sizes
  // ==========================================================================
  localparam int NUM_MOD = 6;
  localparam int CNT_W = 16;
  localparam int WDOG_MOD = 5;

  // ==========================================================================
  // special function register addresses
  // ==========================================================================
  localparam logic [5:0][7:0] MODE_ADDR = {8'hDF, 8'hDE, 8'hDD, 8'hDC, 8'hDB, 8'hDA};
  localparam logic [5:0][7:0] VAL_LOW_ADDR = {8'hCE, 8'hFD, 8'hED, 8'hEB, 8'hE9, 8'hFB};
  localparam logic [5:0][7:0] VAL_HIGH_ADDR = {8'hCF, 8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC};
  localparam logic [7:0] CNT_LOW_ADDR = 8'hF9;
  localparam logic [7:0] CNT_HIGH_ADDR = 8'hFA;

  // ==========================================================================
  // module mode field positions
  // ==========================================================================
  localparam int WIDE_PULSE_BIT = 7;
  localparam int COMPARATOR_BIT = 6;
  localparam int RISING_CAP_BIT = 5;
  localparam int FALLING_CAP_BIT = 4;
  localparam int MATCH_FLAG_BIT = 3;
  localparam int TOGGLE_BIT = 2;
  localparam int PULSE_MODE_BIT = 1;
  localparam int FLAG_IRQ_BIT = 0;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] VAL_RESET = 16'h0000;

  // ==========================================================================
  // cycle length select codes and their counter masks
  // ==========================================================================
  localparam logic [1:0] CYCLE_8 = 2'h0;
  localparam logic [1:0] CYCLE_9 = 2'h1;
  localparam logic [1:0] CYCLE_10 = 2'h2;
  localparam logic [15:0] MASK_8 = 16'h00FF;
  localparam logic [15:0] MASK_9 = 16'h01FF;
  localparam logic [15:0] MASK_10 = 16'h03FF;
  localparam logic [15:0] MASK_11 = 16'h07FF;
  localparam logic [15:0] MASK_16 = 16'hFFFF;
endpackage

// ### design/cca_value_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// capture/compare value store, one 16-bit word per module
// ==========================================================================
module cca_value_mem
  import cca_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // software byte write
  input wire logic sw_we_i,
  input wire logic [2:0] sw_idx_i,
  input wire logic sw_high_i,
  input wire logic [7:0] sw_data_i,
  // hardware word write, one per module
  input wire logic [cca_pkg::NUM_MOD-1:0] hw_we_i,
  input wire logic [cca_pkg::NUM_MOD-1:0][15:0] hw_data_i,
  // all words, straight from the storage flops
  output logic [cca_pkg::NUM_MOD-1:0][15:0] values_o
);
  import cca_pkg::*;

  typedef struct packed {
    logic [NUM_MOD-1:0][15:0] word;
  } cca_mem_t;

  cca_mem_t st;
  cca_mem_t next_st;

  // hardware writes win so a capture is never lost to a software write
  always_comb
  begin
    next_st = st;
    for (int n = 0; n < NUM_MOD; n++)
    begin
      if (hw_we_i[n])
      begin
        next_st.word[n] = hw_data_i[n];
      end
      else if (sw_we_i && sw_idx_i == 3'(n))
      begin
        if (sw_high_i)
        begin
          next_st.word[n][15:8] = sw_data_i;
        end
        else
        begin
          next_st.word[n][7:0] = sw_data_i;
        end
      end
    end
  end

  // state register
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      st.word <= {NUM_MOD{VAL_RESET}};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign values_o = st.word;
endmodule
`default_nettype wire

// ### design/cca_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module cca_mode_ctrl
  import cca_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // special function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // shared controls from neighbouring registers
  input wire logic watchdog_enable_i,
  input wire logic [1:0] cycle_length_select_i,
  input wire logic count_tick_i,
  input wire logic [cca_pkg::NUM_MOD-1:0] flag_clear_i,
  // module pins
  input wire logic [cca_pkg::NUM_MOD-1:0] module_io_pin_i,
  output logic [cca_pkg::NUM_MOD-1:0] module_io_pin_o,
  // flags, requests and counter
  output logic [cca_pkg::NUM_MOD-1:0] module_event_flag_o,
  output logic [cca_pkg::NUM_MOD-1:0] module_irq_o,
  output logic [15:0] counter_o
);
  import cca_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [NUM_MOD-1:0][7:0] mode;
    logic [15:0] counter;
    logic ticked;
    logic [7:0] snapshot;
    logic [7:0] rdata;
    logic [NUM_MOD-1:0] sync1;
    logic [NUM_MOD-1:0] sync2;
    logic [NUM_MOD-1:0] sync3;
    logic [NUM_MOD-1:0] level;
    logic [NUM_MOD-1:0] pin;
    logic [NUM_MOD-1:0] flag;
  } cca_state_t;

  cca_state_t st;
  cca_state_t next_st;

  logic [NUM_MOD-1:0][15:0] values;
  logic [NUM_MOD-1:0] hw_we;
  logic [NUM_MOD-1:0][15:0] hw_data;
  logic sw_we;
  logic [2:0] sw_idx;
  logic sw_high;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    logic [NUM_MOD-1:0] agree;
    logic [NUM_MOD-1:0] rise;
    logic [NUM_MOD-1:0] fall;
    logic [15:0] mask;
    logic [7:0] m;
    logic active;
    logic match;
    logic low_match;
    logic capture;
    logic set_flag;
    agree = '0;
    rise = '0;
    fall = '0;
    mask = MASK_8;
    m = MODE_RESET;
    active = 1'b0;
    match = 1'b0;
    low_match = 1'b0;
    capture = 1'b0;
    set_flag = 1'b0;
    next_st = st;
    hw_we = '0;
    hw_data = '0;
    sw_we = 1'b0;
    sw_idx = 3'h0;
    sw_high = 1'b0;

    // pin synchronisers; a level counts once stages two and three agree
    next_st.sync1 = module_io_pin_i;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    agree = ~(st.sync2 ^ st.sync3);
    rise = agree & st.sync2 & ~st.level;
    fall = agree & ~st.sync2 & st.level;
    next_st.level = (agree & st.sync2) | (~agree & st.level);

    // shared counter; matches are judged only on the cycle after a step
    // so a counter that rests on a value does not fire repeatedly
    next_st.ticked = count_tick_i;
    if (count_tick_i)
    begin
      next_st.counter = st.counter + 16'h0001;
    end
    if (sfr_wr_i && sfr_addr_i == CNT_LOW_ADDR && !watchdog_enable_i)
    begin
      next_st.counter[7:0] = sfr_wdata_i;
    end

    // shared pulse cycle length for modules not in 16-bit mode
    case (cycle_length_select_i)
      CYCLE_8: mask = MASK_8;
      CYCLE_9: mask = MASK_9;
      CYCLE_10: mask = MASK_10;
      default: mask = MASK_11;
    endcase

    // per-module behaviour
    for (int n = 0; n < NUM_MOD; n++)
    begin
      m = st.mode[n];
      // module 5 stops its own functions while it serves the watchdog
      active = !(n == WDOG_MOD && watchdog_enable_i);
      match = active && m[COMPARATOR_BIT] && st.ticked
        && st.counter == values[n];
      low_match = active && m[COMPARATOR_BIT] && st.ticked
        && st.counter[7:0] == values[n][7:0];
      capture = active && ((m[RISING_CAP_BIT] && rise[n])
        || (m[FALLING_CAP_BIT] && fall[n]));
      set_flag = capture || (match && m[MATCH_FLAG_BIT]);
      if (capture)
      begin
        hw_we[n] = 1'b1;
        hw_data[n] = st.counter;
      end
      if (active && m[TOGGLE_BIT] && m[PULSE_MODE_BIT])
      begin
        // frequency output: toggle on low byte match, then advance the
        // low byte by the high byte to set the next half period
        if (low_match)
        begin
          next_st.pin[n] = ~st.pin[n];
          hw_we[n] = 1'b1;
          hw_data[n] = {values[n][15:8], 8'(values[n][7:0] + values[n][15:8])};
        end
      end
      else if (active && m[PULSE_MODE_BIT] && m[COMPARATOR_BIT])
      begin
        // pin high while the counted field is below the module value
        if (m[WIDE_PULSE_BIT])
        begin
          next_st.pin[n] = (st.counter & MASK_16) < (values[n] & MASK_16);
        end
        else
        begin
          next_st.pin[n] = (st.counter & mask) < (values[n] & mask);
        end
      end
      else if (match && m[TOGGLE_BIT])
      begin
        next_st.pin[n] = ~st.pin[n];
      end
      // a set in the same cycle as a clear wins, so no event is lost
      next_st.flag[n] = (st.flag[n] & ~flag_clear_i[n]) | set_flag;

      // software writes to the module registers
      if (sfr_wr_i && active)
      begin
        if (sfr_addr_i == MODE_ADDR[n])
        begin
          next_st.mode[n] = sfr_wdata_i;
        end
        else if (sfr_addr_i == VAL_LOW_ADDR[n])
        begin
          next_st.mode[n][COMPARATOR_BIT] = 1'b0;
          sw_we = 1'b1;
          sw_idx = 3'(n);
          sw_high = 1'b0;
        end
        else if (sfr_addr_i == VAL_HIGH_ADDR[n])
        begin
          next_st.mode[n][COMPARATOR_BIT] = 1'b1;
          sw_we = 1'b1;
          sw_idx = 3'(n);
          sw_high = 1'b1;
        end
      end
    end

    // register reads, answered one cycle after the strobe
    if (sfr_rd_i)
    begin
      next_st.rdata = 8'h00;
      if (sfr_addr_i == CNT_LOW_ADDR)
      begin
        next_st.rdata = st.counter[7:0];
        next_st.snapshot = st.counter[15:8];
      end
      else if (sfr_addr_i == CNT_HIGH_ADDR)
      begin
        next_st.rdata = st.snapshot;
      end
      for (int n = 0; n < NUM_MOD; n++)
      begin
        if (sfr_addr_i == MODE_ADDR[n])
        begin
          next_st.rdata = st.mode[n];
        end
        else if (sfr_addr_i == VAL_LOW_ADDR[n])
        begin
          next_st.rdata = values[n][7:0];
        end
        else if (sfr_addr_i == VAL_HIGH_ADDR[n])
        begin
          next_st.rdata = values[n][15:8];
        end
      end
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      st.mode <= {NUM_MOD{MODE_RESET}};
      st.counter <= CNT_RESET;
      st.ticked <= 1'b0;
      st.snapshot <= 8'h00;
      st.rdata <= 8'h00;
      st.sync1 <= '0;
      st.sync2 <= '0;
      st.sync3 <= '0;
      st.level <= '0;
      st.pin <= '0;
      st.flag <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // value store
  // ==========================================================================
  cca_value_mem u_value_mem (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .sw_we_i(sw_we),
    .sw_idx_i(sw_idx),
    .sw_high_i(sw_high),
    .sw_data_i(sfr_wdata_i),
    .hw_we_i(hw_we),
    .hw_data_i(hw_data),
    .values_o(values)
  );

  // ==========================================================================
  // outputs
  // ==========================================================================
  always_comb
  begin
    for (int n = 0; n < NUM_MOD; n++)
    begin
      module_irq_o[n] = st.flag[n] & st.mode[n][FLAG_IRQ_BIT];
    end
  end

  assign sfr_rdata_o = st.rdata;
  assign module_io_pin_o = st.pin;
  assign module_event_flag_o = st.flag;
  assign counter_o = st.counter;
endmodule
`default_nettype wire

// ### verif/cca_mode_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// port checks on mode control
module cca_mode_ctrl_props
  import cca_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // shared controls
  input wire logic watchdog_enable_i,
  input wire logic count_tick_i,
  input wire logic [cca_pkg::NUM_MOD-1:0] flag_clear_i,
  // flags and counter
  input wire logic [cca_pkg::NUM_MOD-1:0] module_event_flag_o,
  input wire logic [cca_pkg::NUM_MOD-1:0] module_irq_o,
  input wire logic [15:0] counter_o
);
  logic [7:0] snap_q;
  logic rd_lo;
  logic rd_hi;
  logic wr_lo;
  // decoded strobes
  assign rd_lo = sfr_rd_i && sfr_addr_i == CNT_LOW_ADDR;
  assign rd_hi = sfr_rd_i && sfr_addr_i == CNT_HIGH_ADDR;
  assign wr_lo = sfr_wr_i && sfr_addr_i == CNT_LOW_ADDR;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // own copy of the high byte snapshot
  always_ff @(posedge mclk_i)
    if (!reset_n_i)
      snap_q <= 8'h00;
    else if (rd_lo)
      snap_q <= counter_o[15:8];
  irq_gate_a: assert property ((module_irq_o & ~module_event_flag_o) == 6'h00)
    else $error("request without flag");
  low_write_a: assert property (wr_lo && !watchdog_enable_i |=>
    counter_o[7:0] == $past(sfr_wdata_i)) else $error("low byte write lost");
  low_lock_a: assert property (wr_lo && watchdog_enable_i && !count_tick_i |=>
    $stable(counter_o)) else $error("locked low byte changed");
  low_read_a: assert property (rd_lo |=> sfr_rdata_o == $past(counter_o[7:0]))
    else $error("low byte read wrong");
  snap_read_a: assert property (rd_hi |=> sfr_rdata_o == $past(snap_q))
    else $error("snapshot read wrong");
  rdata_hold_a: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data moved");
  count_step_a: assert property (!(wr_lo && !watchdog_enable_i) |=>
    counter_o == $past(counter_o) + 16'($past(count_tick_i))) else $error("counter step");
  flag_hold_a: assert property ($past(reset_n_i) |->
    ($past(module_event_flag_o) & ~module_event_flag_o & ~$past(flag_clear_i)) == 6'h00)
    else $error("flag dropped");
endmodule
bind cca_mode_ctrl cca_mode_ctrl_props i_props (.mclk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i,
  .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .watchdog_enable_i, .count_tick_i, .flag_clear_i,
  .module_event_flag_o, .module_irq_o, .counter_o);
`default_nettype wire

// ### verif/cca_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// external pin drivers
module cca_pin_model
  import cca_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // levels asked for by the bench
  input wire logic [cca_pkg::NUM_MOD-1:0] level_req_i,
  // pins into the block
  output logic [cca_pkg::NUM_MOD-1:0] pin_o
);
  initial pin_o = 6'h00;
  // pins move off the edge, as real pins are not clocked
  always @(posedge mclk_i)
    pin_o <= #2 level_req_i;
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// bench for mode control
module tb_top;
  import cca_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic watchdog_enable_i = 1'b0;
  logic count_tick_i = 1'b0;
  logic [1:0] cycle_length_select_i = CYCLE_8;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic [7:0] d;
  logic [7:0] m;
  logic [5:0] flag_clear_i = 6'h00;
  logic [5:0] level_req = 6'h00;
  logic [5:0] module_io_pin_i;
  logic [5:0] module_io_pin_o;
  logic [5:0] module_event_flag_o;
  logic [5:0] module_irq_o;
  logic [15:0] counter_o;
  logic [15:0] cnt = 16'h0000;
  logic [15:0] v;
  logic [31:0] seed = 32'h8;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #2.5 mclk_i = ~mclk_i;
  cca_mode_ctrl i_dut (.mclk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .watchdog_enable_i, .cycle_length_select_i, .count_tick_i, .flag_clear_i,
    .module_io_pin_i, .module_io_pin_o, .module_event_flag_o, .module_irq_o, .counter_o);
  cca_pin_model i_pins (.mclk_i, .level_req_i(level_req), .pin_o(module_io_pin_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // pin level while counter is below value
  function automatic logic pwm_exp(input logic [15:0] c, input logic [15:0] x,
    input logic [15:0] k);
    return (c & k) < (x & k);
  endfunction
  // counted field for each shared cycle length code
  function automatic logic [15:0] cyc_mask(input logic [1:0] s);
    case (s)
      CYCLE_8: return MASK_8;
      CYCLE_9: return MASK_9;
      CYCLE_10: return MASK_10;
      default: return MASK_11;
    endcase
  endfunction
  task final_report;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge mclk_i) {sfr_addr_i, sfr_wdata_i, sfr_wr_i} <= {a, x, 1'b1};
    @(posedge mclk_i) sfr_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge mclk_i) {sfr_addr_i, sfr_rd_i} <= {a, 1'b1};
    @(posedge mclk_i) sfr_rd_i <= 1'b0;
    #1 x = sfr_rdata_o;
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk_i) count_tick_i <= 1'b1;
    @(posedge mclk_i) count_tick_i <= 1'b0;
    cnt = cnt + 16'(n);
  endtask
  task settle;
    repeat (8) @(posedge mclk_i);
    #1;
  endtask
  task clr(input logic [5:0] b);
    @(posedge mclk_i) flag_clear_i <= b;
    @(posedge mclk_i) flag_clear_i <= 6'h00;
  endtask
  task setv(input int i, input logic [15:0] x);
    wr(VAL_LOW_ADDR[i], x[7:0]);
    wr(VAL_HIGH_ADDR[i], x[15:8]);
  endtask
  // a hang counts as a failure
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      final_report;
    end
  end
  initial
  begin
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < NUM_MOD; i++)
    begin
      rd(MODE_ADDR[i], d);
      chk(d, MODE_RESET);
      seed = xs(seed);
      if (i < WDOG_MOD)
      begin
        wr(MODE_ADDR[i], seed[7:0]);
        rd(MODE_ADDR[i], d);
        chk(d, seed[7:0]);
        wr(MODE_ADDR[i], 8'h00);
      end
    end
    rd(8'h00, d);
    chk(d, 8'h00);
    tick(300);
    rd(CNT_LOW_ADDR, d);
    chk(d, cnt[7:0]);
    v = cnt;
    tick(256);
    rd(CNT_HIGH_ADDR, d);
    chk(d, v[15:8]);
    @(posedge mclk_i) watchdog_enable_i <= 1'b1;
    wr(CNT_LOW_ADDR, 8'h5A);
    wr(MODE_ADDR[WDOG_MOD], 8'hFF);
    rd(MODE_ADDR[WDOG_MOD], d);
    chk(d, 8'h00);
    rd(CNT_LOW_ADDR, d);
    chk(d, cnt[7:0]);
    @(posedge mclk_i) watchdog_enable_i <= 1'b0;
    wr(MODE_ADDR[WDOG_MOD], 8'h81);
    rd(MODE_ADDR[WDOG_MOD], d);
    chk(d, 8'h81);
    wr(CNT_LOW_ADDR, 8'h10);
    cnt[7:0] = 8'h10;
    rd(CNT_LOW_ADDR, d);
    chk(d, cnt[7:0]);
    wr(VAL_HIGH_ADDR[0], 8'h00);
    rd(MODE_ADDR[0], d);
    chk(d, 8'h40);
    wr(VAL_LOW_ADDR[0], 8'h00);
    rd(MODE_ADDR[0], d);
    chk(d, 8'h00);
    setv(3, 16'h0080);
    wr(MODE_ADDR[3], 8'h42);
    settle;
    chk(module_io_pin_o[3], pwm_exp(cnt, 16'h0080, MASK_8));
    wr(MODE_ADDR[3], 8'hC2);
    settle;
    chk(module_io_pin_o[3], pwm_exp(cnt, 16'h0080, MASK_16));
    // every shared cycle length with a random module value
    for (int k = 0; k < 4; k++)
    begin
      seed = xs(seed);
      @(posedge mclk_i) cycle_length_select_i <= 2'(k);
      setv(3, seed[15:0]);
      wr(MODE_ADDR[3], 8'h42);
      settle;
      chk(module_io_pin_o[3], pwm_exp(cnt, seed[15:0], cyc_mask(2'(k))));
    end
    wr(MODE_ADDR[3], 8'h00);
    wr(MODE_ADDR[1], 8'h49);
    setv(1, cnt + 16'h3);
    tick(5);
    settle;
    chk(module_event_flag_o[1], 1'b1);
    chk(module_irq_o[1], 1'b1);
    wr(MODE_ADDR[1], 8'h48);
    settle;
    chk(module_irq_o[1], 1'b0);
    clr(6'h02);
    settle;
    chk(module_event_flag_o[1], 1'b0);
    wr(MODE_ADDR[2], 8'h44);
    setv(2, cnt + 16'h3);
    tick(5);
    settle;
    chk(module_io_pin_o[2], 1'b1);
    wr(MODE_ADDR[4], 8'h46);
    v = {8'h05, cnt[7:0] + 8'h2};
    setv(4, v);
    tick(3);
    settle;
    chk(module_io_pin_o[4], 1'b1);
    rd(VAL_LOW_ADDR[4], d);
    chk(d, 8'(v[7:0] + v[15:8]));
    for (int k = 1; k < 4; k++)
    begin
      m = 8'(k << 4);
      wr(MODE_ADDR[0], m);
      level_req[0] <= 1'b1;
      settle;
      chk(module_event_flag_o[0], m[5]);
      if (m[5])
      begin
        rd(VAL_LOW_ADDR[0], d);
        chk(d, cnt[7:0]);
      end
      clr(6'h01);
      level_req[0] <= 1'b0;
      settle;
      chk(module_event_flag_o[0], m[4]);
      clr(6'h01);
    end
    // reset in mid-run puts counter, pins and modes back to rest
    @(posedge mclk_i) reset_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    #1;
    chk(counter_o, CNT_RESET);
    chk(module_io_pin_o, 6'h00);
    chk(module_event_flag_o, 6'h00);
    rd(MODE_ADDR[2], d);
    chk(d, MODE_RESET);
    final_report;
  end
endmodule
`default_nettype wire
